/* File: beam_eval_process_data_tb_top.sv */
// Self-checking bench for the beam process-data block
`timescale 1ns/1ns
module beam_eval_process_data_tb_top import bepd_pkg::*;;
  logic         sys_clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic         meas_strobe_i = 1'b0;
  logic [255:0] beam_blocked_i = '0;
  logic [31:0]  area_state_i = '0;
  logic [15:0]  out_state_i = '0;
  logic [15:0]  status_i = '0;
  logic [3:0]   key_press_i = '0;
  logic [3:0]   key_press_o;
  logic         param_wr_i, param_rd_i, param_ack_o, param_err_o;
  logic         pd_valid_o, panel_lock_o, e;
  logic [7:0]   param_index_i;
  logic [127:0] param_wdata_i, param_rdata_o, q, sel;
  logic [255:0] pd_image_o, prev, filt, a, b;
  int           fails = 0, checks = 0, cyc = 0, depth = 1, cnt = 0;
  logic [7:0]   bad [6] = '{8'h70, 8'hC7, 8'hCE, 8'hCF, 8'hD3, 8'hFF};
  always #20 sys_clk_i = ~sys_clk_i;
  bepd_top #(.MS_CYCLES(10)) u_dut (.sys_clk_i, .rst_n_i, .meas_strobe_i,
    .beam_blocked_i, .area_state_i, .out_state_i, .status_i, .key_press_i,
    .param_wr_i, .param_rd_i, .param_index_i, .param_wdata_i,
    .param_rdata_o, .param_ack_o, .param_err_o, .pd_image_o, .pd_valid_o,
    .key_press_o, .panel_lock_o);
  bepd_master u_mst (.sys_clk_i, .param_ack_o, .param_err_o, .param_rdata_o,
    .param_wr_i, .param_rd_i, .param_index_i, .param_wdata_i);
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] x,
                     input logic [127:0] d);
    u_mst.xfer(w, x, d, q, e);
    chk(256'(param_ack_o), 256'h1);
  endtask
  function automatic logic [15:0] slot(input logic [7:0] c,
                                       input logic [255:0] m);
    int f, l, n, s;
    f = 0;
    l = 0;
    n = 0;
    s = 16 * (int'(c) - 1);
    for (int i = 0; i < 256; i++) begin
      if (m[i] == !c[0]) begin
        if (f == 0) f = i + 1;
        l = i + 1;
        n++;
      end
    end
    if (c >= 8'h01 && c <= 8'h6F) begin
      for (int i = 0; i < 16; i++) begin
        slot[i] = (s + i < 256) ? m[s + i] : 1'b0;
      end
    end else begin
      case (c)
        8'hC8, 8'hC9: slot = f[15:0];
        8'hCA, 8'hCB: slot = l[15:0];
        8'hCC, 8'hCD: slot = n[15:0];
        8'hD0: slot = area_state_i[15:0];
        8'hD1: slot = area_state_i[31:16];
        8'hD2: slot = out_state_i;
        8'hD4: slot = status_i;
        default: slot = 16'h0000;
      endcase
    end
  endfunction
  function automatic logic [255:0] img(input logic [255:0] m);
    for (int k = 0; k < 16; k++) begin
      img[255 - 16 * k -: 16] = slot(sel[127 - 8 * k -: 8], m);
    end
  endfunction
  task automatic meas(input logic [255:0] m);
    @(posedge sys_clk_i);
    meas_strobe_i <= 1'b1;
    beam_blocked_i <= m;
    cnt = (m === prev) ? ((cnt < 255) ? cnt + 1 : 255) : 1;
    prev = m;
    if (cnt >= depth) filt = m;
    @(posedge sys_clk_i);
    meas_strobe_i <= 1'b0;
  endtask
  task automatic pd_wait(output int n);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pd_valid_o !== 1'b1 && n < 100);
    chk(256'(pd_valid_o), 256'h1);
  endtask
  task automatic rnd(output logic [255:0] m);
    for (int w = 0; w < 8; w++) m[32 * w +: 32] = $urandom;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    int n;
    void'($urandom(32'h529d8b6c));
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    acc(0, IDX_PD_SEL, '0);
    chk(q, {SEL1_DEF, 120'h0});
    acc(0, IDX_EXT, '0);
    chk(q, 128'h0001_0000);
    acc(0, IDX_LOCK, '0);
    chk(q, '0);
    sel = 128'hC8C9_CACB_CCCD_D0D1_D2D4_0102_1011_006F;
    acc(1, IDX_PD_SEL, sel);
    chk(256'(e), '0);
    foreach (bad[i]) begin
      acc(1, IDX_PD_SEL, {sel[127:16], bad[i], 8'h00});
      chk(256'(e), 256'h1);
    end
    acc(1, IDX_EXT, 128'h0000_0005);
    chk(256'(e), 256'h1);
    acc(0, IDX_PD_SEL, '0);
    chk(q, sel);
    acc(0, 8'h50, '0);
    chk({q, 127'h0, e}, 256'h1);
    repeat (4) begin
      rnd(a);
      area_state_i <= $urandom;
      out_state_i <= 16'($urandom);
      status_i <= 16'($urandom);
      meas(a);
      pd_wait(n);
      chk(pd_image_o, img(filt));
    end
    acc(1, IDX_EXT, 128'h0003_0000);
    depth = 3;
    rnd(a);
    rnd(b);
    for (int i = 0; i < 6; i++) begin
      meas((i < 3) ? a : b);
      pd_wait(n);
      chk(pd_image_o, img(filt));
    end
    acc(1, IDX_EXT, 128'h0001_0002);
    depth = 1;
    pd_wait(n);
    meas(a);
    meas(b);
    pd_wait(n);
    chk(pd_image_o, img(a | b));
    key_press_i <= 4'hA;
    acc(1, IDX_LOCK, 128'h1);
    @(posedge sys_clk_i);
    chk({key_press_o, panel_lock_o}, 5'h01);
    acc(1, IDX_LOCK, 128'h2);
    chk({e, panel_lock_o}, 2'h3);
    acc(1, IDX_LOCK, 128'h0);
    @(posedge sys_clk_i);
    chk({key_press_o, panel_lock_o}, 5'h14);
    end_of_test;
  end
endmodule

/* File: bepd_beam_stats.sv */
// Registered first/last/total statistics over a beam image
`timescale 1ns/1ns
module bepd_beam_stats import bepd_pkg::*; #(
  parameter int NUM_BEAMS = 256
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 upd_i,
  input  wire logic [NUM_BEAMS-1:0] img_i,
  output logic      [SLOT_W-1:0]    first_blk_o,
  output logic      [SLOT_W-1:0]    first_clr_o,
  output logic      [SLOT_W-1:0]    last_blk_o,
  output logic      [SLOT_W-1:0]    last_clr_o,
  output logic      [SLOT_W-1:0]    cnt_blk_o,
  output logic      [SLOT_W-1:0]    cnt_clr_o,
  output logic                      valid_o
);
  typedef struct packed {
    logic [SLOT_W-1:0] first_blk;
    logic [SLOT_W-1:0] first_clr;
    logic [SLOT_W-1:0] last_blk;
    logic [SLOT_W-1:0] last_clr;
    logic [SLOT_W-1:0] cnt_blk;
    logic [SLOT_W-1:0] cnt_clr;
    logic              valid;
  } bepd_stats_t;

  bepd_stats_t st_r, st_nxt;

  always_comb begin
    logic [SLOT_W-1:0] num;
    num    = '0;
    st_nxt = st_r;
    st_nxt.valid = 1'b0;
    if (upd_i) begin
      st_nxt.first_blk = '0;
      st_nxt.first_clr = '0;
      st_nxt.last_blk  = '0;
      st_nxt.last_clr  = '0;
      st_nxt.cnt_blk   = '0;
      st_nxt.cnt_clr   = '0;
      st_nxt.valid     = 1'b1;
      for (int i = NUM_BEAMS - 1; i >= 0; i--) begin
        num = SLOT_W'(i + 1);
        if (img_i[i]) begin
          st_nxt.first_blk = num;
        end else begin
          st_nxt.first_clr = num;
        end
      end
      for (int i = 0; i < NUM_BEAMS; i++) begin
        num = SLOT_W'(i + 1);
        if (img_i[i]) begin
          st_nxt.last_blk = num;
          st_nxt.cnt_blk  = st_nxt.cnt_blk + 1'b1;
        end else begin
          st_nxt.last_clr = num;
          st_nxt.cnt_clr  = st_nxt.cnt_clr + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign first_blk_o = st_r.first_blk;
  assign first_clr_o = st_r.first_clr;
  assign last_blk_o  = st_r.last_blk;
  assign last_clr_o  = st_r.last_clr;
  assign cnt_blk_o   = st_r.cnt_blk;
  assign cnt_clr_o   = st_r.cnt_clr;
  assign valid_o     = st_r.valid;
endmodule

/* File: bepd_master.sv */
// Parameter master model moving whole records
`timescale 1ns/1ns
module bepd_master import bepd_pkg::*; (
  input  wire logic             sys_clk_i,
  input  wire logic             param_ack_o,
  input  wire logic             param_err_o,
  input  wire logic [REC_W-1:0] param_rdata_o,
  output logic                  param_wr_i = 1'b0,
  output logic                  param_rd_i = 1'b0,
  output logic      [7:0]       param_index_i = 8'h00,
  output logic      [REC_W-1:0] param_wdata_i = '0
);
  task automatic xfer(input logic w, input logic [7:0] x,
                      input logic [REC_W-1:0] d,
                      output logic [REC_W-1:0] q, output logic e);
    int n;
    @(posedge sys_clk_i);
    param_wr_i <= w;
    param_rd_i <= !w;
    param_index_i <= x;
    param_wdata_i <= d;
    @(posedge sys_clk_i);
    param_wr_i <= 1'b0;
    param_rd_i <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (param_ack_o !== 1'b1 && n < 8);
    q = param_rdata_o;
    e = param_err_o;
    param_index_i <= ~x;
    param_wdata_i <= ~d;
  endtask
endmodule

/* File: bepd_monitor.sv */
// Port checks for the beam process-data block
`timescale 1ns/1ns
module bepd_monitor import bepd_pkg::*; #(
  parameter int KEYS = 4
) (
  input wire logic             sys_clk_i,
  input wire logic             rst_n_i,
  input wire logic             param_wr_i,
  input wire logic             param_rd_i,
  input wire logic [7:0]       param_index_i,
  input wire logic [REC_W-1:0] param_wdata_i,
  input wire logic [REC_W-1:0] param_rdata_o,
  input wire logic             param_ack_o,
  input wire logic             param_err_o,
  input wire logic [PD_W-1:0]  pd_image_o,
  input wire logic             pd_valid_o,
  input wire logic [KEYS-1:0]  key_press_i,
  input wire logic [KEYS-1:0]  key_press_o,
  input wire logic             panel_lock_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire known = param_index_i == IDX_PD_SEL || param_index_i == IDX_EXT ||
               param_index_i == IDX_LOCK;
  sequence s_req; param_wr_i || param_rd_i; endsequence
  sequence s_lock_wr; param_wr_i && param_index_i == IDX_LOCK; endsequence
  property p_ack; s_req |=> param_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_unk; s_req ##0 !known |=> param_err_o; endproperty
  a_unk: assert property (p_unk) else $error("no err");
  property p_rd_zero;
    param_rd_i && !param_wr_i && !known |=> param_rdata_o == '0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("rdata");
  property p_lock_set;
    s_lock_wr ##0 param_wdata_i[7:1] == 7'h00 |=>
      panel_lock_o == $past(param_wdata_i[0]);
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock");
  property p_lock_bad;
    s_lock_wr ##0 param_wdata_i[7:1] != 7'h00 |=>
      param_err_o && $stable(panel_lock_o);
  endproperty
  a_lock_bad: assert property (p_lock_bad) else $error("lock err");
  property p_key_lock; panel_lock_o ##1 panel_lock_o |-> key_press_o == '0;
  endproperty
  a_key_lock: assert property (p_key_lock) else $error("key");
  property p_key_pass;
    !panel_lock_o ##1 !panel_lock_o |-> key_press_o == $past(key_press_i);
  endproperty
  a_key_pass: assert property (p_key_pass) else $error("key");
  property p_pd_hold; !pd_valid_o |-> $stable(pd_image_o); endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("image");
endmodule
bind bepd_top bepd_monitor #(.KEYS(KEYS)) u_mon (.sys_clk_i, .rst_n_i,
  .param_wr_i, .param_rd_i, .param_index_i, .param_wdata_i, .param_rdata_o,
  .param_ack_o, .param_err_o, .pd_image_o, .pd_valid_o, .key_press_i,
  .key_press_o, .panel_lock_o);

/* File: bepd_pkg.sv */
// Constants and helpers shared by the beam evaluation process-data block
package bepd_pkg;
  localparam logic [7:0]  IDX_PD_SEL    = 8'h48;
  localparam logic [7:0]  IDX_EXT       = 8'h4A;
  localparam logic [7:0]  IDX_LOCK      = 8'h4E;
  localparam int          SEL_W         = 8;
  localparam int          NUM_SEL       = 16;
  localparam int          SLOT_W        = 16;
  localparam int          PD_BYTES      = 32;
  localparam int          PD_W          = PD_BYTES * 8;
  localparam int          FILT_LSB      = 16;
  localparam int          INTEG_LSB     = 0;
  localparam int          REC_W         = 128;
  localparam int          EXT_W         = 32;
  localparam int          LOCK_W        = 8;
  localparam logic [7:0]  FILT_DEF      = 8'h01;
  localparam logic [15:0] INTEG_DEF     = 16'h0000;
  localparam logic [7:0]  SEL1_DEF      = 8'hCA;
  localparam logic [7:0]  SEL_OFF       = 8'h00;
  localparam logic [7:0]  SEL_RAW_MAX   = 8'h6F;
  localparam logic [7:0]  SEL_FIRST_BLK = 8'hC8;
  localparam logic [7:0]  SEL_FIRST_CLR = 8'hC9;
  localparam logic [7:0]  SEL_LAST_BLK  = 8'hCA;
  localparam logic [7:0]  SEL_LAST_CLR  = 8'hCB;
  localparam logic [7:0]  SEL_CNT_BLK   = 8'hCC;
  localparam logic [7:0]  SEL_CNT_CLR   = 8'hCD;
  localparam logic [7:0]  SEL_AREA_LO   = 8'hD0;
  localparam logic [7:0]  SEL_AREA_HI   = 8'hD1;
  localparam logic [7:0]  SEL_OUTS      = 8'hD2;
  localparam logic [7:0]  SEL_STATUS    = 8'hD4;
  localparam logic [7:0]  LOCK_MAX      = 8'h01;
  localparam int          CASCADE_BEAMS = 16;
  localparam int          MS_NS         = 1000000;
  localparam int          CLK_NS        = 40;
  localparam int          CLK_PER_MS    = MS_NS / CLK_NS;

  // Legal selector codes
  function automatic logic sel_valid(input logic [7:0] v);
    sel_valid = (v <= SEL_RAW_MAX) ||
                (v >= SEL_FIRST_BLK && v <= SEL_CNT_CLR) ||
                (v >= SEL_AREA_LO && v <= SEL_OUTS) ||
                (v == SEL_STATUS);
  endfunction
endpackage

/* File: bepd_top.sv */
// Beam filter, hold, parameter records and process-data assembly
`timescale 1ns/1ns
module bepd_top import bepd_pkg::*; #(
  parameter int NUM_BEAMS  = 256,
  parameter int MS_CYCLES  = CLK_PER_MS,
  parameter int KEYS       = 4
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 meas_strobe_i,
  input  wire logic [NUM_BEAMS-1:0] beam_blocked_i,
  input  wire logic [31:0]          area_state_i,
  input  wire logic [SLOT_W-1:0]    out_state_i,
  input  wire logic [SLOT_W-1:0]    status_i,
  input  wire logic [KEYS-1:0]      key_press_i,
  input  wire logic                 param_wr_i,
  input  wire logic                 param_rd_i,
  input  wire logic [7:0]           param_index_i,
  input  wire logic [REC_W-1:0]     param_wdata_i,
  output logic      [REC_W-1:0]     param_rdata_o,
  output logic                      param_ack_o,
  output logic                      param_err_o,
  output logic      [PD_W-1:0]      pd_image_o,
  output logic                      pd_valid_o,
  output logic      [KEYS-1:0]      key_press_o,
  output logic                      panel_lock_o
);
  localparam int MSC_W = $clog2(MS_CYCLES + 1);

  typedef struct packed {
    logic [REC_W-1:0]     sel;
    logic [7:0]           filt_depth;
    logic [15:0]          integ;
    logic                 lock;
    logic                 ack;
    logic                 err;
    logic [REC_W-1:0]     rdata;
    logic [NUM_BEAMS-1:0] last_img;
    logic [7:0]           same_cnt;
    logic [NUM_BEAMS-1:0] filt_img;
    logic [NUM_BEAMS-1:0] acc;
    logic [NUM_BEAMS-1:0] held;
    logic [NUM_BEAMS-1:0] stat_img;
    logic [MSC_W-1:0]     cyc_cnt;
    logic [15:0]          ms_cnt;
    logic                 upd;
    logic [PD_W-1:0]      pd;
    logic                 pd_valid;
    logic [KEYS-1:0]      keys;
  } bepd_state_t;

  bepd_state_t s_r, s_nxt;

  logic [SLOT_W-1:0] first_blk, first_clr, last_blk, last_clr;
  logic [SLOT_W-1:0] cnt_blk, cnt_clr;
  logic              stats_valid;

  bepd_beam_stats #(
    .NUM_BEAMS (NUM_BEAMS)
  ) u_stats (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .upd_i       (s_r.upd),
    .img_i       (s_r.held),
    .first_blk_o (first_blk),
    .first_clr_o (first_clr),
    .last_blk_o  (last_blk),
    .last_clr_o  (last_clr),
    .cnt_blk_o   (cnt_blk),
    .cnt_clr_o   (cnt_clr),
    .valid_o     (stats_valid)
  );

  // Raw beam bits of one 16-beam cascade, zero past the beam count
  function automatic logic [SLOT_W-1:0] cascade_bits(
    input logic [NUM_BEAMS-1:0] img,
    input logic [7:0]           n
  );
    int base;
    base = (int'(n) - 1) * CASCADE_BEAMS;
    cascade_bits = '0;
    for (int b = 0; b < CASCADE_BEAMS; b++) begin
      if (base + b < NUM_BEAMS && base + b < PD_W) begin
        cascade_bits[b] = img[base + b];
      end
    end
  endfunction

  // Selects the content of one process-data slot
  function automatic logic [SLOT_W-1:0] slot_word(
    input logic [7:0]           v,
    input logic [NUM_BEAMS-1:0] img
  );
    slot_word = '0;
    case (v)
      SEL_OFF:       slot_word = '0;
      SEL_FIRST_BLK: slot_word = first_blk;
      SEL_FIRST_CLR: slot_word = first_clr;
      SEL_LAST_BLK:  slot_word = last_blk;
      SEL_LAST_CLR:  slot_word = last_clr;
      SEL_CNT_BLK:   slot_word = cnt_blk;
      SEL_CNT_CLR:   slot_word = cnt_clr;
      SEL_AREA_LO:   slot_word = area_state_i[15:0];
      SEL_AREA_HI:   slot_word = area_state_i[31:16];
      SEL_OUTS:      slot_word = out_state_i;
      SEL_STATUS:    slot_word = status_i;
      default: begin
        if (v <= SEL_RAW_MAX) begin
          slot_word = cascade_bits(img, v);
        end
      end
    endcase
  endfunction

  always_comb begin
    logic       ok;
    logic [7:0] v;
    logic [7:0] nd;
    ok    = 1'b1;
    v     = '0;
    nd    = '0;
    s_nxt = s_r;
    s_nxt.ack      = 1'b0;
    s_nxt.upd      = 1'b0;
    s_nxt.pd_valid = 1'b0;

    // Whole-record parameter access with range check
    if (param_wr_i) begin
      s_nxt.ack = 1'b1;
      case (param_index_i)
        IDX_PD_SEL: begin
          for (int k = 0; k < NUM_SEL; k++) begin
            v = param_wdata_i[REC_W-1-k*SEL_W -: SEL_W];
            if (!sel_valid(v)) begin
              ok = 1'b0;
            end
          end
          if (ok) begin
            s_nxt.sel = param_wdata_i;
          end
        end
        IDX_EXT: begin
          nd = param_wdata_i[FILT_LSB +: 8];
          ok = (nd != 8'h00);
          if (ok) begin
            s_nxt.filt_depth = nd;
            s_nxt.integ      = param_wdata_i[INTEG_LSB +: 16];
          end
        end
        IDX_LOCK: begin
          ok = (param_wdata_i[LOCK_W-1:0] <= LOCK_MAX);
          if (ok) begin
            s_nxt.lock = param_wdata_i[0];
          end
        end
        default: ok = 1'b0;
      endcase
      s_nxt.err = !ok;
    end else if (param_rd_i) begin
      s_nxt.ack   = 1'b1;
      s_nxt.err   = 1'b0;
      s_nxt.rdata = '0;
      case (param_index_i)
        IDX_PD_SEL: s_nxt.rdata = s_r.sel;
        IDX_EXT: begin
          s_nxt.rdata[FILT_LSB +: 8]   = s_r.filt_depth;
          s_nxt.rdata[INTEG_LSB +: 16] = s_r.integ;
        end
        IDX_LOCK: s_nxt.rdata[0] = s_r.lock;
        default:  s_nxt.err = 1'b1;
      endcase
    end

    // Consistency filter over consecutive measurement passes
    if (meas_strobe_i) begin
      if (beam_blocked_i == s_r.last_img) begin
        if (s_r.same_cnt != 8'hFF) begin
          s_nxt.same_cnt = s_r.same_cnt + 8'h01;
        end
      end else begin
        s_nxt.same_cnt = 8'h01;
        s_nxt.last_img = beam_blocked_i;
      end
      if (s_nxt.same_cnt >= s_r.filt_depth) begin
        s_nxt.filt_img = beam_blocked_i;
      end
    end

    // Millisecond divider and hold interval
    if (s_r.cyc_cnt == MSC_W'(MS_CYCLES - 1)) begin
      s_nxt.cyc_cnt = '0;
      if (s_r.integ != 16'h0000) begin
        s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;
      end
    end else begin
      s_nxt.cyc_cnt = s_r.cyc_cnt + 1'b1;
    end

    if (s_r.integ == 16'h0000) begin
      s_nxt.ms_cnt = '0;
      s_nxt.acc    = '0;
      if (meas_strobe_i) begin
        s_nxt.held = s_nxt.filt_img;
        s_nxt.upd  = 1'b1;
      end
    end else begin
      if (meas_strobe_i) begin
        s_nxt.acc = s_r.acc | s_nxt.filt_img;
      end
      if (s_nxt.ms_cnt >= s_r.integ) begin
        s_nxt.held   = s_nxt.acc;
        s_nxt.acc    = '0;
        s_nxt.ms_cnt = '0;
        s_nxt.upd    = 1'b1;
      end
    end

    // Image behind the current statistics
    if (s_r.upd) begin
      s_nxt.stat_img = s_r.held;
    end

    // Process image assembly after the statistics settle
    if (stats_valid) begin
      for (int k = 0; k < NUM_SEL; k++) begin
        s_nxt.pd[PD_W-1-k*SLOT_W -: SLOT_W] =
          slot_word(s_r.sel[REC_W-1-k*SEL_W -: SEL_W], s_r.stat_img);
      end
      s_nxt.pd_valid = 1'b1;
    end

    s_nxt.keys = s_r.lock ? '0 : key_press_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r            <= '0;
      s_r.sel        <= {SEL1_DEF, {(REC_W-SEL_W){1'b0}}};
      s_r.filt_depth <= FILT_DEF;
      s_r.integ      <= INTEG_DEF;
      s_r.lock       <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign param_rdata_o = s_r.rdata;
  assign param_ack_o   = s_r.ack;
  assign param_err_o   = s_r.err;
  assign pd_image_o    = s_r.pd;
  assign pd_valid_o    = s_r.pd_valid;
  assign key_press_o   = s_r.keys;
  assign panel_lock_o  = s_r.lock;
endmodule
